/* File: arau_pkg.sv */
// Purpose: Shared constants and types of the aux register address unit.
// Assumes: APB register map with byte addresses, 32-bit data.
// Notes: Command word fields drive one instruction per accepted write.
package arau_pkg;
    localparam logic [7:0] A_CMD   = 8'h00;
    localparam logic [7:0] A_ACC   = 8'h04;
    localparam logic [7:0] A_PROD  = 8'h08;
    localparam logic [7:0] A_TVAL  = 8'h0C;
    localparam logic [7:0] A_AUX0  = 8'h10;
    localparam logic [7:0] A_AUX1  = 8'h14;
    localparam logic [7:0] A_STATE = 8'h18;
    localparam logic [7:0] A_BTGT  = 8'h1C;
    localparam logic [7:0] A_MADDR = 8'h20;
    localparam logic [7:0] A_MDATA = 8'h24;

    localparam int F_OP   = 0;
    localparam int F_IND  = 4;
    localparam int F_MOD  = 5;
    localparam int F_CHG  = 7;
    localparam int F_NPTR = 8;
    localparam int F_TGT  = 9;
    localparam int F_DIR  = 10;
    localparam int F_IMM  = 17;

    localparam int PC_W     = 12;
    localparam int CNT_W    = 9;
    localparam int STK_LVLS = 4;
    localparam logic [11:0] RST_PC = 12'h000;

    localparam logic [1:0] MOD_NONE = 2'h0;
    localparam logic [1:0] MOD_INC  = 2'h1;
    localparam logic [1:0] MOD_DEC  = 2'h2;

    typedef enum logic [3:0] {
        OP_NOP    = 4'h0,
        OP_PTRLDI = 4'h1,
        OP_PAGELD = 4'h2,
        OP_MODPTR = 4'h3,
        OP_BCNZ   = 4'h4,
        OP_AUXLDI = 4'h5,
        OP_AUXLD  = 4'h6,
        OP_AUXST  = 4'h7,
        OP_CALLA  = 4'h8,
        OP_RETURN = 4'h9,
        OP_SHIFT  = 4'hA,
        OP_LTADD  = 4'hB
    } arau_op_t;

    typedef struct packed {
        logic             ptr;
        logic             dp;
        logic [1:0][15:0] aux;
        logic [11:0]      pc;
        logic [3:0][11:0] stk;
        logic [2:0]       depth;
        logic             taken;
        logic [31:0]      acc;
        logic [31:0]      prod;
        logic [15:0]      treg;
        logic [11:0]      btgt;
        logic [7:0]       maddr;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } arau_state_t;

    // Only the counter field moves; the upper bits hold their value.
    function automatic logic [15:0] aux_step(input logic [15:0] v,
                                             input logic [1:0]  m);
        case (m)
            MOD_INC: return {v[15:9], 9'(v[8:0] + 9'h001)};
            MOD_DEC: return {v[15:9], 9'(v[8:0] - 9'h001)};
            default: return v;
        endcase
    endfunction
endpackage

/* File: arau_top.sv */
// Purpose: Aux register pointer, address forming and program control.
// Assumes: One instruction per APB write to the command register.
// Notes: Data RAM lives here; program ROM is fed from PROG_ADDR_OUT.
`timescale 1ns/1ns
`default_nettype none
module arau_top
    import arau_pkg::*;
#(
    parameter int DATA_WORDS = 256,
    parameter int PROG_WORDS = 4096
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic      [11:0] PROG_ADDR_OUT
);
    generate
        if ((DATA_WORDS != 144 && DATA_WORDS != 256) ||
            PROG_WORDS < 1 || PROG_WORDS > 4096) begin : g_chk
            $error("arau_top: unsupported memory size");
        end
    endgenerate

    arau_state_t s_q;
    arau_state_t s_d;
    logic [15:0] ram [0:255];
    logic        ram_we;
    logic [7:0]  ram_wa;
    logic [15:0] ram_wd;

    arau_op_t    op;
    logic        ind;
    logic [1:0]  md;
    logic        chg;
    logic        nptr;
    logic        tgt;
    logic [6:0]  dir;
    logic [7:0]  imm;
    logic [7:0]  op_addr;
    logic [15:0] rd_word;
    logic [15:0] sel_aux;
    logic        exec;
    logic        setup;
    logic        wr_take;
    logic        post_mod;
    logic [11:0] pc_inc;

    function automatic logic in_ram(input logic [7:0] a);
        return {1'b0, a} < 9'(DATA_WORDS);
    endfunction

    function automatic logic [15:0] ram_rd(input logic [7:0] a);
        return in_ram(a) ? ram[a] : 16'h0000;
    endfunction

    always_comb begin
        op   = arau_op_t'(PWDATA_IN[F_OP +: 4]);
        ind  = PWDATA_IN[F_IND];
        md   = PWDATA_IN[F_MOD +: 2];
        chg  = PWDATA_IN[F_CHG];
        nptr = PWDATA_IN[F_NPTR];
        tgt  = PWDATA_IN[F_TGT];
        dir  = PWDATA_IN[F_DIR +: 7];
        imm  = PWDATA_IN[F_IMM +: 8];
    end

    assign sel_aux  = s_q.aux[s_q.ptr];
    // Address uses the unmodified register; the step lands afterwards.
    assign op_addr  = ind ? sel_aux[7:0] : {s_q.dp, dir};
    assign rd_word  = ram_rd(op_addr);
    assign setup    = PSEL_IN & ~PENABLE_IN;
    assign wr_take  = PSEL_IN & PENABLE_IN & PWRITE_IN & s_q.pready;
    assign exec     = wr_take & (PADDR_IN == A_CMD);
    assign pc_inc   = 12'(s_q.pc + 12'h001);
    assign post_mod = (op == OP_MODPTR) |
                      (ind & (op == OP_AUXLD || op == OP_AUXST ||
                              op == OP_SHIFT || op == OP_LTADD));

    always_comb begin
        s_d         = s_q;
        ram_we      = 1'b0;
        ram_wa      = op_addr;
        ram_wd      = rd_word;
        s_d.pready  = setup;
        s_d.pslverr = 1'b0;
        if (setup) begin
            s_d.prdata = 32'h0000_0000;
            case (PADDR_IN)
                A_CMD:   s_d.prdata = 32'h0000_0000;
                A_ACC:   s_d.prdata = s_q.acc;
                A_PROD:  s_d.prdata = s_q.prod;
                A_TVAL:  s_d.prdata = {16'h0000, s_q.treg};
                A_AUX0:  s_d.prdata = {16'h0000, s_q.aux[0]};
                A_AUX1:  s_d.prdata = {16'h0000, s_q.aux[1]};
                A_STATE: s_d.prdata = {14'h0000, s_q.depth, s_q.taken,
                                       s_q.dp, s_q.ptr, s_q.pc};
                A_BTGT:  s_d.prdata = {20'h00000, s_q.btgt};
                A_MADDR: s_d.prdata = {24'h000000, s_q.maddr};
                A_MDATA: s_d.prdata = {16'h0000, ram_rd(s_q.maddr)};
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (wr_take) begin
            case (PADDR_IN)
                A_ACC:   s_d.acc = PWDATA_IN;
                A_PROD:  s_d.prod = PWDATA_IN;
                A_BTGT:  s_d.btgt = PWDATA_IN[11:0];
                A_MADDR: s_d.maddr = PWDATA_IN[7:0];
                A_MDATA: begin
                    ram_we = 1'b1;
                    ram_wa = s_q.maddr;
                    ram_wd = PWDATA_IN[15:0];
                end
                default: ;
            endcase
        end
        if (exec) begin
            // The fetch address moves on while this word is executed.
            s_d.pc = pc_inc;
            if (post_mod) begin
                s_d.aux[s_q.ptr] = aux_step(sel_aux, md);
                if (chg) begin
                    s_d.ptr = nptr;
                end
            end
            case (op)
                OP_PTRLDI: s_d.ptr = nptr;
                OP_PAGELD: s_d.dp = nptr;
                OP_BCNZ: begin
                    s_d.taken = sel_aux[CNT_W-1:0] != 9'h000;
                    if (sel_aux[CNT_W-1:0] != 9'h000) begin
                        s_d.pc = s_q.btgt;
                    end
                    s_d.aux[s_q.ptr] = aux_step(sel_aux, MOD_DEC);
                    if (chg) begin
                        s_d.ptr = nptr;
                    end
                end
                OP_AUXLDI: s_d.aux[tgt] = {8'h00, imm};
                OP_AUXLD:  s_d.aux[tgt] = rd_word;
                OP_AUXST: begin
                    ram_we = 1'b1;
                    ram_wd = s_q.aux[tgt];
                end
                OP_CALLA: begin
                    s_d.stk = {s_q.stk[2:0], pc_inc};
                    s_d.pc  = s_q.acc[PC_W-1:0];
                    if (s_q.depth != 3'(STK_LVLS)) begin
                        s_d.depth = 3'(s_q.depth + 3'h1);
                    end
                end
                OP_RETURN: begin
                    s_d.pc  = s_q.stk[0];
                    s_d.stk = {s_q.stk[3], s_q.stk[3:1]};
                    if (s_q.depth != 3'h0) begin
                        s_d.depth = 3'(s_q.depth - 3'h1);
                    end
                end
                OP_SHIFT: begin
                    ram_we = 1'b1;
                    ram_wa = 8'(op_addr + 8'h01);
                end
                OP_LTADD: begin
                    ram_we  = 1'b1;
                    ram_wa  = 8'(op_addr + 8'h01);
                    s_d.treg = rd_word;
                    s_d.acc  = 32'(s_q.acc + s_q.prod);
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            s_q    <= '0;
            s_q.pc <= RST_PC;
        end else begin
            s_q <= s_d;
        end
    end

    // Writes past a 144-word part are dropped rather than aliased.
    always_ff @(posedge CLOCK_IN) begin
        if (ram_we && in_ram(ram_wa)) begin
            ram[ram_wa] <= ram_wd;
        end
    end

    assign PRDATA_OUT    = s_q.prdata;
    assign PREADY_OUT    = s_q.pready;
    assign PSLVERR_OUT   = s_q.pslverr;
    assign PROG_ADDR_OUT = s_q.pc;

    sequence s_op(arau_op_t o);
        exec && op == o;
    endsequence

    property p_ptr_load;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        s_op(OP_PTRLDI) |=> s_q.ptr == $past(nptr);
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer load did not take immediate");

    property p_late_ptr;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_op(OP_AUXLD) and (ind && chg && tgt != s_q.ptr)) |=>
            s_q.ptr == $past(nptr) &&
            s_q.aux[$past(tgt)] == $past(rd_word);
    endproperty
    a_late_ptr: assert property (p_late_ptr)
        else $error("pointer change was not deferred");

    property p_branch;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        s_op(OP_BCNZ) |=> s_q.pc == ($past(sel_aux[8:0]) != 9'h000 ?
                                     $past(s_q.btgt) : $past(pc_inc));
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch count nonzero took wrong path");

    property p_wrap;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_op(OP_BCNZ) and (sel_aux[8:0] == 9'h000 && !chg)) |=>
            s_q.aux[s_q.ptr][8:0] == 9'h1FF;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to all ones");

    property p_modify;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_op(OP_MODPTR) and (md == MOD_INC && !chg)) |=>
            s_q.aux[s_q.ptr][8:0] == 9'($past(sel_aux[8:0]) + 9'h001) &&
            $stable(s_q.acc);
    endproperty
    a_modify: assert property (p_modify)
        else $error("modify pointer op misbehaved");

    property p_keep_ptr;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_op(OP_AUXLDI)) |=> $stable(s_q.ptr) &&
            s_q.aux[$past(tgt)] == {8'h00, $past(imm)};
    endproperty
    a_keep_ptr: assert property (p_keep_ptr)
        else $error("immediate aux load wrong");

    sequence s_call;
        s_op(OP_CALLA);
    endsequence
    sequence s_ret;
        s_op(OP_RETURN);
    endsequence

    property p_call;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        s_call |=> s_q.pc == $past(s_q.acc[11:0]) &&
                   s_q.stk[0] == 12'($past(s_q.pc) + 12'h001);
    endproperty
    a_call: assert property (p_call)
        else $error("call from accumulator wrong");

    // Commands are at least two bus cycles apart, so a return is judged
    // against the call that was the last command, whatever the spacing.
    logic        chk_call_q;
    logic [11:0] chk_ret_q;

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            chk_call_q <= 1'b0;
            chk_ret_q  <= 12'h000;
        end else if (exec) begin
            chk_call_q <= op == OP_CALLA;
            chk_ret_q  <= 12'(s_q.pc + 12'h001);
        end
    end

    property p_return;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_ret and chk_call_q) |=> s_q.pc == $past(chk_ret_q);
    endproperty
    a_return: assert property (p_return)
        else $error("return did not resume after call");

    property p_fetch;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (exec && op inside {OP_NOP, OP_AUXLD, OP_SHIFT}) |=>
            s_q.pc == 12'($past(s_q.pc) + 12'h001);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch address did not advance");

    property p_shift;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_op(OP_SHIFT) and (op_addr < 8'h8F)) |=>
            ram[8'($past(op_addr) + 8'h01)] == $past(rd_word) &&
            $stable(s_q.acc);
    endproperty
    a_shift: assert property (p_shift)
        else $error("shift word up failed");

    property p_ltadd;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        s_op(OP_LTADD) |=> s_q.treg == $past(rd_word) &&
            s_q.acc == 32'($past(s_q.acc) + $past(s_q.prod));
    endproperty
    a_ltadd: assert property (p_ltadd)
        else $error("load T and add failed");

    property p_direct;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_op(OP_AUXST) and !ind) |-> ##1
            ram_rd({$past(s_q.dp), $past(dir)}) == $past(s_q.aux[tgt]);
    endproperty
    a_direct: assert property (p_direct)
        else $error("direct store went to wrong address");

    property p_indirect;
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        (s_op(OP_AUXST) and (ind && md == MOD_NONE && tgt != s_q.ptr))
            |=> ram_rd($past(sel_aux[7:0])) == $past(s_q.aux[tgt]);
    endproperty
    a_indirect: assert property (p_indirect)
        else $error("indirect store went to wrong address");
endmodule
`default_nettype wire

/* File: arau_rom_model.sv */
// Purpose: Program ROM seen from the fetch address of the unit.
// Assumes: One fetch per clock; the unit registers the fetch address.
// Notes: Content is a plain pattern; fault flags a fetch outside the ROM.
`timescale 1ns/1ns
`default_nettype none
module arau_rom_model #(
    parameter int WORDS = 4096
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [11:0] addr_in,
    output logic      [15:0] word_out,
    output logic             fault_out
);
    // The fetch runs every cycle, beside the data access of the unit.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            word_out  <= 16'h0000;
            fault_out <= 1'h0;
        end else begin
            word_out <= {4'hA, addr_in};
            // The fault is sticky so a single stray fetch is never missed.
            if (32'(addr_in) >= WORDS) begin
                fault_out <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench of the aux register address unit.
// Assumes: APB slave may add wait states; a transfer fails after 20 polled edges.
// Notes: Expected values are tracked here; pc follows every command.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import arau_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] prog_addr;
    logic [15:0] rom_word;
    logic        rom_fault;
    logic        last_err;
    logic [11:0] pc;
    logic [31:0] v;
    int          errors;
    int          checked;

    arau_top dut (.CLOCK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .PROG_ADDR_OUT(prog_addr));
    arau_rom_model #(.WORDS(1524)) rom (.clk_in(clk), .rst_in(rst),
        .addr_in(prog_addr),
        .word_out(rom_word), .fault_out(rom_fault));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] cw(input arau_op_t op,
        input logic [1:0] md, input logic ind, input logic chg,
        input logic np, input logic tg, input logic [6:0] dir,
        input logic [7:0] imm);
        logic [31:0] w;
        w = 32'h0;
        w[F_OP +: 4] = op;
        w[F_MOD +: 2] = md;
        w[F_IND] = ind;
        w[F_CHG] = chg;
        w[F_NPTR] = np;
        w[F_TGT] = tg;
        w[F_DIR +: 7] = dir;
        w[F_IMM +: 8] = imm;
        return w;
    endfunction

    function automatic logic [31:0] sw(input logic [11:0] p,
        input logic pt, input logic pg, input logic [2:0] d);
        return {14'h0, d, 1'h0, pg, pt, p};
    endfunction

    task give_verdict;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The request stands until the rising edge that samples pready high;
    // read data and the error flag are taken at that same edge.
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rd);
        int   n;
        logic r;
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            r = pready;
            rd = prdata;
            last_err = pslverr;
            n++;
        end while (r !== 1'h1 && n < 20);
        psel    <= 1'h0;
        penable <= 1'h0;
        if (r !== 1'h1) begin
            errors++;
            give_verdict;
        end
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'h1, a, d, x);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        xfer(1'h0, a, 32'h0, d);
    endtask

    task chk_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        rd(a, x);
        chk(x, exp);
    endtask

    // The last-branch flag is masked; only the loop task judges it.
    task chk_st(input logic [11:0] p, input logic pt, input logic pg,
                input logic [2:0] d);
        logic [31:0] x;
        rd(A_STATE, x);
        chk(x & 32'hFFFF_BFFF, sw(p, pt, pg, d));
    endtask

    task ex(input logic [31:0] w);
        wr(A_CMD, w);
        pc = pc + 12'h001;
    endtask

    task mem(input logic [7:0] a, input logic [31:0] d);
        wr(A_MADDR, {24'h0, a});
        wr(A_MDATA, d);
    endtask

    task run_loop(input int n);
        int          p;
        logic [31:0] x;
        p = 0;
        do begin
            ex(cw(OP_BCNZ, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'h00));
            p++;
            rd(A_STATE, x);
        end while (x[14] === 1'h1 && p < 600);
        pc = 12'h041;
        chk(32'(p), 32'(n + 1));
        chk({20'h0, x[11:0]}, 32'h41);
    endtask

    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst = 1'h1;
        errors = 0;
        checked = 0;
        pc = 12'h000;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        chk_st(12'h000, 1'h0, 1'h0, 3'h0);
        chk({20'h0, prog_addr}, 32'h0);
        rd(8'h30, v);
        chk({31'h0, last_err}, 32'h1);
        chk(v, 32'h0);
        ex(cw(OP_AUXLDI, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h1, 7'h00, 8'h05));
        chk_rd(A_AUX1, 32'h5);
        chk_st(pc, 1'h0, 1'h0, 3'h0);
        mem(8'h03, 32'h0105);
        mem(8'h05, 32'h1234);
        ex(cw(OP_AUXLD, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h1, 7'h03, 8'h00));
        chk_rd(A_AUX1, 32'h0105);
        ex(cw(OP_PTRLDI, MOD_NONE, 1'h0, 1'h0, 1'h1, 1'h0, 7'h00, 8'h00));
        chk_st(pc, 1'h1, 1'h0, 3'h0);
        ex(cw(OP_AUXLD, MOD_INC, 1'h1, 1'h1, 1'h0, 1'h0, 7'h00, 8'h00));
        chk_rd(A_AUX0, 32'h1234);
        chk_rd(A_AUX1, 32'h0106);
        chk_st(pc, 1'h0, 1'h0, 3'h0);
        wr(A_ACC, 32'h11);
        ex(cw(OP_MODPTR, MOD_DEC, 1'h1, 1'h0, 1'h0, 1'h0, 7'h00, 8'h00));
        chk_rd(A_AUX0, 32'h1233);
        chk_rd(A_AUX1, 32'h0106);
        chk_rd(A_ACC, 32'h11);
        ex(cw(OP_MODPTR, MOD_INC, 1'h1, 1'h0, 1'h0, 1'h0, 7'h00, 8'h00));
        chk_rd(A_AUX0, 32'h1234);
        ex(cw(OP_PAGELD, MOD_NONE, 1'h0, 1'h0, 1'h1, 1'h0, 7'h00, 8'h00));
        mem(8'h83, 32'hBEEF);
        ex(cw(OP_AUXLD, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h03, 8'h00));
        chk_rd(A_AUX0, 32'hBEEF);
        chk_st(pc, 1'h0, 1'h1, 3'h0);
        ex(cw(OP_AUXST, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h1, 7'h04, 8'h00));
        wr(A_MADDR, 32'h84);
        chk_rd(A_MDATA, 32'h0106);
        ex(cw(OP_AUXST, MOD_NONE, 1'h1, 1'h0, 1'h0, 1'h1, 7'h00, 8'h00));
        wr(A_MADDR, 32'hEF);
        chk_rd(A_MDATA, 32'h0106);
        ex(cw(OP_NOP, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'h00));
        chk_st(pc, 1'h0, 1'h1, 3'h0);
        ex(cw(OP_PAGELD, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'h00));
        mem(8'h10, 32'hAAAA);
        ex(cw(OP_SHIFT, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h10, 8'h00));
        wr(A_MADDR, 32'h11);
        chk_rd(A_MDATA, 32'hAAAA);
        chk_rd(A_ACC, 32'h11);
        mem(8'h20, 32'h7777);
        wr(A_PROD, 32'h5);
        ex(cw(OP_LTADD, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h20, 8'h00));
        chk_rd(A_TVAL, 32'h7777);
        chk_rd(A_ACC, 32'h16);
        wr(A_MADDR, 32'h21);
        chk_rd(A_MDATA, 32'h7777);
        mem(8'h40, 32'hFFFF_FFFF);
        chk_rd(A_MDATA, 32'hFFFF);
        wr(A_BTGT, 32'h40);
        ex(cw(OP_AUXLDI, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'h03));
        run_loop(3);
        chk_rd(A_AUX0, 32'h01FF);
        mem(8'h50, 32'hFFFF);
        ex(cw(OP_AUXLD, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h50, 8'h00));
        run_loop(511);
        chk_rd(A_AUX0, 32'hFFFF);
        for (int i = 1; i <= 5; i++) begin
            wr(A_ACC, 32'hFFFF_F000 | (32'(i) << 8));
            ex(cw(OP_CALLA, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'h00));
            pc = 12'(i << 8);
        end
        chk_st(12'h500, 1'h0, 1'h0, 3'h4);
        chk({20'h0, prog_addr}, 32'h500);
        for (int k = 1; k <= 4; k++) begin
            ex(cw(OP_RETURN, MOD_NONE, 1'h0, 1'h0, 1'h0, 1'h0, 7'h00, 8'h00));
            pc = 12'((5 - k) << 8) + 12'h001;
            chk_st(pc, 1'h0, 1'h0, 3'(4 - k));
        end
        chk({20'h0, prog_addr}, 32'h101);
        chk({16'h0, rom_word}, {16'h0, 4'hA, 12'h101});
        chk({31'h0, rom_fault}, 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
